//--- verilog/sdc_cfg.svh
// register map, field positions, codes and timing counts of the spi dma control block
`ifndef SDC_CFG_SVH
`define SDC_CFG_SVH

// register indices; byte address is four times the index
`define SDC_IDX_TXP   12'hf80
`define SDC_IDX_RXP   12'hf82
`define SDC_IDX_CNT   12'hf84
`define SDC_IDX_DWC   12'hf86
`define SDC_IDX_MODE  12'hf88
`define SDC_IDX_STAT  12'hf8a
`define SDC_ADDR(idx) ({idx, 2'b00})
`define SDC_AV_AW     14

// reset values
`define SDC_MODE_RST  8'h00
`define SDC_DWC_RST   8'h00
`define SDC_PTR_RST   12'h000

// delay/watermark register fields
`define SDC_WM_LO     0
`define SDC_GAP_LO    4
`define SDC_FLD_W     4
`define SDC_WM_W      10
// watermark levels in remaining bytes, code 4'hf first
`define SDC_WM_TABLE  {10'h240, 10'h200, 10'h1c0, 10'h180, 10'h140, 10'h100, 10'h0c0, 10'h080, \
                       10'h043, 10'h020, 10'h010, 10'h008, 10'h004, 10'h002, 10'h001, 10'h000}

// status register bits
`define SDC_STAT_IRQ  0
`define SDC_STAT_BUSY 1

// codes
`define SDC_DUP_FULL  2'b10
`define SDC_DUP_TX    2'b01
`define SDC_DUP_RX    2'b00
`define SDC_SEL_OFF   2'b00
`define SDC_SEL_1     2'b10
`define SDC_SEL_2     2'b01
`define SDC_SEL_4     2'b11
`define SDC_RATE_D4   2'b00
`define SDC_RATE_D16  2'b01
`define SDC_RATE_D64  2'b10

// inter-byte timing in instruction cycles
`define SDC_BASE_D4   5'h08
`define SDC_BASE_D16  5'h09
`define SDC_BASE_D64  5'h0f
`define SDC_PIPE_CYC  12'h005
`define SDC_GAP_STEP  12'h080
`define SDC_GAP_BIAS  12'h002
`define SDC_GAP_1110  12'h400
`define SDC_GAP_1111  12'h800
`define SDC_IDLE_TX   8'hff

`endif

//--- verilog/sdc_pkg.sv
// types and the gap decode shared by the spi dma control block
`include "sdc_cfg.svh"
package sdc_pkg;

  typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_READ, ST_LOAD, ST_SHIFT, ST_GAP} sdc_state_t;

  typedef struct packed {
    logic [1:0] sel;
    logic       tx_ptr_autoinc;
    logic       rx_ptr_autoinc;
    logic [1:0] duplex;
    logic       gapIrqEn;
    logic       run;
  } sdc_mode_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } sdc_mem_req_t;

  typedef struct packed {
    logic       start;
    logic       txEn;
    logic       rxEn;
    logic [7:0] data;
  } sdc_xfer_t;

  function automatic logic [11:0] sdc_gap_decode(input logic [3:0] code);
    logic [11:0] v;
    v = 12'h001;
    case (code)
      4'he:    v = `SDC_GAP_1110;
      4'hf:    v = `SDC_GAP_1111;
      default: begin
        if (!code[3]) v = 12'h001 << code[2:0];
        else v = `SDC_GAP_STEP * ({9'h000, code[2:0]} + `SDC_GAP_BIAS);
      end
    endcase
    return v;
  endfunction

endpackage

//--- verilog/sdc_gap_timer.sv
// down counter that pulses once a loaded number of cycles after its load
`timescale 1ns/100ps
module sdc_gap_timer #(
  parameter int W = 12
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // control
  input  wire logic         enable,
  input  wire logic         load,
  input  wire logic [W-1:0] loadVal,
  // event
  output logic              expire
);
  logic [W-1:0] cnt_ff, nxt_cnt;
  logic         armed_ff, nxt_armed;
  logic         exp_ff, nxt_exp;

  if (W < 2 || W > 16) begin : g_chk
    $error("sdc_gap_timer: W out of range");
  end

  // expire rises loadVal cycles after the load edge; a value of zero acts as one
  always_comb begin
    nxt_cnt   = cnt_ff;
    nxt_armed = armed_ff;
    nxt_exp   = 1'b0;
    if (!enable) begin
      nxt_cnt   = '0;
      nxt_armed = 1'b0;
    end else if (load) begin
      nxt_cnt   = loadVal;
      nxt_armed = 1'b1;
    end else if (armed_ff) begin
      if (cnt_ff <= W'(1)) begin
        nxt_armed = 1'b0;
        nxt_exp   = 1'b1;
      end else begin
        nxt_cnt = cnt_ff - W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff   <= '0;
      armed_ff <= 1'b0;
      exp_ff   <= 1'b0;
    end else begin
      cnt_ff   <= nxt_cnt;
      armed_ff <= nxt_armed;
      exp_ff   <= nxt_exp;
    end
  end

  assign expire = exp_ff;
endmodule

//--- verilog/sdc_sel_gen.sv
// automatic slave select: low from fetch of a group's first byte until its last byte ends
`timescale 1ns/100ps
`include "sdc_cfg.svh"
module sdc_sel_gen (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // engine events
  input  wire logic       active,
  input  wire logic [1:0] selCode,
  input  wire logic       byteStart,
  input  wire logic       byteDone,
  input  wire logic       lastByte,
  // pin
  output logic            selN
);
  logic [1:0] grpCnt_ff, nxt_grpCnt;
  logic       selN_ff, nxt_selN;
  logic [1:0] grpMax;
  always_comb begin
    case (selCode)
      `SDC_SEL_2: grpMax = 2'h1;
      `SDC_SEL_4: grpMax = 2'h3;
      default:    grpMax = 2'h0;
    endcase
  end

  always_comb begin
    nxt_grpCnt = grpCnt_ff;
    nxt_selN   = selN_ff;
    if (!active) begin
      nxt_grpCnt = 2'h0;
      nxt_selN   = 1'b1;
    end else begin
      if (byteStart) nxt_selN = 1'b0;
      if (byteDone) begin
        if (grpCnt_ff == grpMax || lastByte) begin
          nxt_grpCnt = 2'h0;
          nxt_selN   = 1'b1;
        end else begin
          nxt_grpCnt = grpCnt_ff + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      grpCnt_ff <= 2'h0;
      selN_ff   <= 1'b1;
    end else begin
      grpCnt_ff <= nxt_grpCnt;
      selN_ff   <= nxt_selN;
    end
  end

  assign selN = selN_ff;
endmodule

//--- verilog/sdc_spi_dma_control.sv
// spi dma control engine with avalon-mm register slave
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "sdc_cfg.svh"
// Function
// - master: select code 11/01/10 holds select low for four/two/one bytes; 00 leaves it alone
// - delay interrupt enable forced clear whenever select control is non-zero
// - transmit pointer steps per byte sent only when transmit increment is on
// - receive pointer steps per byte received only when receive increment is on
// - duplex 10 full, 01 transmit only, 00 receive only, master or slave
// - master: setting run starts byte exchange at once
// - slave: setting run only prepares; the outside master clocks the bytes
// - run bit set by software, cleared by engine on completion or by software to abort
// - clearing run mid byte lets that byte finish, then engine idles
// - after run cleared, no pointer, count or memory activity
// - slave with delay interrupt: flag raised when byte gap exceeds delay count
// - slave without delay interrupt: only watermark and completion flags
// - master without delay interrupt: extra idle cycles from delay field between bytes
// - master minimum gap 8, 9 or 15 cycles by serial clock divider
// - master with delay interrupt: one extra cycle, time-out logic stays active
// - second register: delay field high nibble, watermark level low nibble
// - delay codes give 1..128 doubling, then 128 steps, 1024, 2048
// - watermark code picks remaining count raising the flag; completion also raises it
// - zero-based ten-bit count decrements per byte; after last byte engine stops
// - pointers are twelve bits and address general sram only
module sdc_spi_dma_control #(
  parameter int CNT_W = 10
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rstn,
  // avalon-mm register slave
  input  wire logic [`SDC_AV_AW-1:0]    avAddress,
  input  wire logic                     avRead,
  input  wire logic                     avWrite,
  input  wire logic [3:0]               avByteEnable,
  input  wire logic [31:0]              avWriteData,
  output logic [31:0]                   avReadData,
  output logic                          avWaitRequest,
  // spi shift engine
  input  wire logic                     masterMode,
  input  wire logic [1:0]               clkRateSel,
  input  wire logic                     byteDone,
  input  wire logic [7:0]               rxByte,
  output sdc_pkg::sdc_xfer_t            xferReq,
  output logic                          autoSlaveSelectN,
  // general sram
  output sdc_pkg::sdc_mem_req_t         memReq,
  input  wire logic [7:0]               memRdata,
  // status
  output logic                          portIrqFlag,
  output logic                          engineRun
);
  import sdc_pkg::*;

  if (CNT_W < 10 || CNT_W > 16) begin : g_chk
    $error("sdc_spi_dma_control: CNT_W out of range");
  end

  localparam logic [16*`SDC_WM_W-1:0] WM_TABLE = `SDC_WM_TABLE;

  sdc_state_t   state_ff, nxt_state;
  sdc_mode_t    mode_ff, nxt_mode;
  logic [7:0]   dwc_ff, nxt_dwc;
  logic [11:0]  txPtr_ff, nxt_txPtr;
  logic [11:0]  rxPtr_ff, nxt_rxPtr;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic         irq_ff, nxt_irq;
  logic         wmPrev_ff, nxt_wmPrev;
  logic         dwcWr_ff, nxt_dwcWr;
  sdc_mem_req_t mem_ff, nxt_mem;
  sdc_xfer_t    xfer_ff, nxt_xfer;
  logic [31:0]  rd_ff, nxt_rd;
  logic         wait_ff, nxt_wait;

  logic         wrEn;
  logic [31:0]  rdMux;
  logic         txUsed;
  logic         rxUsed;
  logic         lastByte;
  logic         wmHit;
  logic [`SDC_WM_W-1:0] wmLevel;
  logic [4:0]   gapBase;
  logic [11:0]  gapDelay;
  logic [11:0]  gapExtra;
  logic [11:0]  gapLoadVal;
  logic         gapLoad;
  logic         gapDone;
  logic         toutLoad;
  logic         toutExpire;
  logic         selActive;

  // ---- avalon slave: one wait cycle, read data registered with the answer
  assign wrEn = avWrite && !wait_ff;

  always_comb begin
    rdMux = 32'h0000_0000;
    case (avAddress)
      `SDC_ADDR(`SDC_IDX_MODE): rdMux = 32'(mode_ff);
      `SDC_ADDR(`SDC_IDX_DWC):  rdMux = 32'(dwc_ff);
      `SDC_ADDR(`SDC_IDX_TXP):  rdMux = 32'(txPtr_ff);
      `SDC_ADDR(`SDC_IDX_RXP):  rdMux = 32'(rxPtr_ff);
      `SDC_ADDR(`SDC_IDX_CNT):  rdMux = 32'(cnt_ff);
      `SDC_ADDR(`SDC_IDX_STAT): begin
        rdMux[`SDC_STAT_IRQ]  = irq_ff;
        rdMux[`SDC_STAT_BUSY] = (state_ff != ST_IDLE);
      end
      default:                  rdMux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    nxt_wait = !((avRead || avWrite) && wait_ff);
    nxt_rd   = rd_ff;
    if (avRead && wait_ff) nxt_rd = rdMux;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_ff <= 1'b1;
      rd_ff   <= 32'h0000_0000;
    end else begin
      wait_ff <= nxt_wait;
      rd_ff   <= nxt_rd;
    end
  end

  // ---- derived controls
  assign txUsed   = (mode_ff.duplex != `SDC_DUP_RX);
  assign rxUsed   = (mode_ff.duplex != `SDC_DUP_TX);
  assign lastByte = (cnt_ff == '0) || !mode_ff.run;
  assign wmLevel  = WM_TABLE[dwc_ff[`SDC_WM_LO +: `SDC_FLD_W] * `SDC_WM_W +: `SDC_WM_W];
  // remaining bytes are count plus one, so level above count means reached
  assign wmHit    = mode_ff.run && (wmLevel != '0) && (int'(cnt_ff) < int'(wmLevel));
  assign gapDelay = sdc_gap_decode(dwc_ff[`SDC_GAP_LO +: `SDC_FLD_W]);

  always_comb begin
    case (clkRateSel)
      `SDC_RATE_D4:  gapBase = `SDC_BASE_D4;
      `SDC_RATE_D16: gapBase = `SDC_BASE_D16;
      default:       gapBase = `SDC_BASE_D64;
    endcase
  end

  // with the delay interrupt on the gap shrinks to one cycle over the base
  assign gapExtra   = mode_ff.gapIrqEn ? 12'h001 : gapDelay;
  assign gapLoadVal = 12'({7'h00, gapBase}) + gapExtra - `SDC_PIPE_CYC;
  assign toutLoad   = byteDone || (state_ff == ST_IDLE);
  assign selActive  = masterMode && (mode_ff.sel != `SDC_SEL_OFF) && (state_ff != ST_IDLE);

  sdc_gap_timer #(.W(12)) u_gap (
    .clk     (clk),
    .rstn    (rstn),
    .enable  (mode_ff.run),
    .load    (gapLoad),
    .loadVal (gapLoadVal),
    .expire  (gapDone)
  );

  // time-out watch stays live in master mode too when the delay interrupt is on
  sdc_gap_timer #(.W(12)) u_tout (
    .clk     (clk),
    .rstn    (rstn),
    .enable  (mode_ff.run && mode_ff.gapIrqEn),
    .load    (toutLoad),
    .loadVal (gapDelay),
    .expire  (toutExpire)
  );

  sdc_sel_gen u_sel (
    .clk       (clk),
    .rstn      (rstn),
    .active    (selActive),
    .selCode   (mode_ff.sel),
    .byteStart (state_ff == ST_FETCH),
    .byteDone  (byteDone && state_ff == ST_SHIFT),
    .lastByte  (lastByte),
    .selN      (autoSlaveSelectN)
  );

  // ---- engine and register file
  always_comb begin
    nxt_state     = state_ff;
    nxt_mode      = mode_ff;
    nxt_dwc       = dwc_ff;
    nxt_txPtr     = txPtr_ff;
    nxt_rxPtr     = rxPtr_ff;
    nxt_cnt       = cnt_ff;
    nxt_irq       = irq_ff;
    nxt_wmPrev    = wmHit;
    nxt_dwcWr     = 1'b0;
    nxt_mem       = mem_ff;
    nxt_mem.rd    = 1'b0;
    nxt_mem.wr    = 1'b0;
    nxt_xfer      = xfer_ff;
    nxt_xfer.start = 1'b0;
    gapLoad       = 1'b0;

    // software writes; engine updates below take priority
    if (wrEn) begin
      case (avAddress)
        `SDC_ADDR(`SDC_IDX_MODE): if (avByteEnable[0]) begin
          nxt_mode = sdc_mode_t'(avWriteData[7:0]);
          if (nxt_mode.sel != `SDC_SEL_OFF) nxt_mode.gapIrqEn = 1'b0;
        end
        `SDC_ADDR(`SDC_IDX_DWC): if (avByteEnable[0]) begin
          nxt_dwc   = avWriteData[7:0];
          nxt_dwcWr = 1'b1;
        end
        `SDC_ADDR(`SDC_IDX_TXP): begin
          if (avByteEnable[0]) nxt_txPtr[7:0]  = avWriteData[7:0];
          if (avByteEnable[1]) nxt_txPtr[11:8] = avWriteData[11:8];
        end
        `SDC_ADDR(`SDC_IDX_RXP): begin
          if (avByteEnable[0]) nxt_rxPtr[7:0]  = avWriteData[7:0];
          if (avByteEnable[1]) nxt_rxPtr[11:8] = avWriteData[11:8];
        end
        `SDC_ADDR(`SDC_IDX_CNT): begin
          if (avByteEnable[0]) nxt_cnt[7:0]       = avWriteData[7:0];
          if (avByteEnable[1]) nxt_cnt[CNT_W-1:8] = avWriteData[CNT_W-1:8];
        end
        `SDC_ADDR(`SDC_IDX_STAT): begin
          if (avByteEnable[0] && avWriteData[`SDC_STAT_IRQ]) nxt_irq = 1'b0;
        end
        default: ;
      endcase
    end

    // flag sets come after the clear so a same-cycle event is kept
    if (wmHit && (!wmPrev_ff || dwcWr_ff)) nxt_irq = 1'b1;
    if (toutExpire) nxt_irq = 1'b1;

    case (state_ff)
      ST_IDLE: begin
        if (mode_ff.run) nxt_state = ST_FETCH;
      end
      ST_FETCH: begin
        if (!mode_ff.run) begin
          nxt_state = ST_IDLE;
        end else begin
          nxt_mem.rd   = txUsed;
          nxt_mem.addr = txPtr_ff;
          nxt_state    = ST_READ;
        end
      end
      ST_READ: begin
        nxt_state = mode_ff.run ? ST_LOAD : ST_IDLE;
      end
      ST_LOAD: begin
        if (!mode_ff.run) begin
          nxt_state = ST_IDLE;
        end else begin
          // in slave mode this only primes the shifter; the outside master clocks it
          nxt_xfer.start = 1'b1;
          nxt_xfer.txEn  = txUsed;
          nxt_xfer.rxEn  = rxUsed;
          nxt_xfer.data  = txUsed ? memRdata : `SDC_IDLE_TX;
          nxt_state      = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (byteDone) begin
          if (!mode_ff.run) begin
            nxt_state = ST_IDLE;
          end else begin
            if (rxUsed) begin
              nxt_mem.wr    = 1'b1;
              nxt_mem.addr  = rxPtr_ff;
              nxt_mem.wdata = rxByte;
              if (mode_ff.rx_ptr_autoinc) nxt_rxPtr = rxPtr_ff + 12'h001;
            end
            if (txUsed && mode_ff.tx_ptr_autoinc) nxt_txPtr = txPtr_ff + 12'h001;
            if (cnt_ff == '0) begin
              nxt_mode.run = 1'b0;
              nxt_irq      = 1'b1;
              nxt_state    = ST_IDLE;
            end else begin
              nxt_cnt = cnt_ff - CNT_W'(1);
              if (masterMode) begin
                gapLoad   = 1'b1;
                nxt_state = ST_GAP;
              end else begin
                nxt_state = ST_FETCH;
              end
            end
          end
        end
      end
      ST_GAP: begin
        if (!mode_ff.run) nxt_state = ST_IDLE;
        else if (gapDone) nxt_state = ST_FETCH;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff  <= ST_IDLE;
      mode_ff   <= sdc_mode_t'(`SDC_MODE_RST);
      dwc_ff    <= `SDC_DWC_RST;
      txPtr_ff  <= `SDC_PTR_RST;
      rxPtr_ff  <= `SDC_PTR_RST;
      cnt_ff    <= '0;
      irq_ff    <= 1'b0;
      wmPrev_ff <= 1'b0;
      dwcWr_ff  <= 1'b0;
      mem_ff    <= '0;
      xfer_ff   <= '0;
    end else begin
      state_ff  <= nxt_state;
      mode_ff   <= nxt_mode;
      dwc_ff    <= nxt_dwc;
      txPtr_ff  <= nxt_txPtr;
      rxPtr_ff  <= nxt_rxPtr;
      cnt_ff    <= nxt_cnt;
      irq_ff    <= nxt_irq;
      wmPrev_ff <= nxt_wmPrev;
      dwcWr_ff  <= nxt_dwcWr;
      mem_ff    <= nxt_mem;
      xfer_ff   <= nxt_xfer;
    end
  end

  assign avReadData    = rd_ff;
  assign avWaitRequest = wait_ff;
  assign xferReq       = xfer_ff;
  assign memReq        = mem_ff;
  assign portIrqFlag   = irq_ff;
  assign engineRun     = mode_ff.run;
endmodule

//--- test/sdc_spi_dma_control_sva.sv
// assertion checker for the spi dma control block ports
`timescale 1ns/100ps
`include "sdc_cfg.svh"
module sdc_spi_dma_control_sva #(
  parameter int CNT_W = 10
) (
  // clock and reset
  input wire logic                  clk,
  input wire logic                  rstn,
  // register bus
  input wire logic [`SDC_AV_AW-1:0] avAddress,
  input wire logic                  avRead,
  input wire logic                  avWrite,
  input wire logic [31:0]           avWriteData,
  input wire logic                  avWaitRequest,
  // engine side
  input wire logic                  masterMode,
  input wire logic [1:0]            clkRateSel,
  input wire logic                  byteDone,
  input wire sdc_pkg::sdc_xfer_t    xferReq,
  input wire logic                  autoSlaveSelectN,
  input wire sdc_pkg::sdc_mem_req_t memReq,
  input wire logic                  portIrqFlag,
  input wire logic                  engineRun
);
  import sdc_pkg::*;
  logic [1:0] selR, dupR;
  logic [3:0] gsR, wmR;
  logic       gapR, modeWr, dwcWr;
  assign modeWr = avWrite && !avWaitRequest && avAddress == `SDC_ADDR(`SDC_IDX_MODE);
  assign dwcWr  = avWrite && !avWaitRequest && avAddress == `SDC_ADDR(`SDC_IDX_DWC);
  // shadow of what software wrote; a select code keeps the gap irq enable clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {selR, dupR, gapR, gsR, wmR} <= 13'h0000;
    end else begin
      if (modeWr) begin
        {selR, dupR} <= {avWriteData[7:6], avWriteData[3:2]};
        gapR <= avWriteData[1] && avWriteData[7:6] == 2'b00;
      end
      if (dwcWr) begin
        {gsR, wmR} <= avWriteData[7:0];
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  bus_wait_one_a: assert property (
    (avRead || avWrite) && avWaitRequest |=> !avWaitRequest ##1 avWaitRequest)
    else $error("bus access not answered after one wait cycle");
  run_by_sw_a: assert property ($rose(engineRun) |-> $past(avWrite))
    else $error("run bit set without a software write");
  master_start_a: assert property (
    modeWr && avWriteData[0] && masterMode && !engineRun |-> ##[4:6] xferReq.start)
    else $error("master run did not start a byte");
  master_gap_a: assert property (
    byteDone && engineRun && masterMode && clkRateSel == 2'b00 && gsR == 4'h0 && !gapR
    |=> (!xferReq.start)[*8] ##1 (xferReq.start || !engineRun))
    else $error("master inter byte gap not nine cycles");
  sel_low_a: assert property (
    xferReq.start && masterMode && selR != 2'b00 |-> !autoSlaveSelectN)
    else $error("select not low during a byte");
  sel_off_a: assert property (
    selR == 2'b00 && $past(selR) == 2'b00 |-> autoSlaveSelectN)
    else $error("select driven with select control off");
  done_flag_a: assert property (
    $fell(engineRun) && !$past(avWrite) |-> ##[0:1] portIrqFlag)
    else $error("completion did not raise the flag");
  rx_only_a: assert property (dupR == 2'b00 && engineRun |-> !memReq.rd)
    else $error("memory read in receive only mode");
  tx_only_a: assert property (dupR == 2'b01 |-> !memReq.wr)
    else $error("memory write in transmit only mode");
  slave_quiet_a: assert property (
    !masterMode && !gapR && wmR == 4'h0 && engineRun && $past(engineRun)
    |-> !$rose(portIrqFlag))
    else $error("slave flag raised without a cause");
  cover property (xferReq.start && !autoSlaveSelectN);
  cover property (byteDone && engineRun && !masterMode);
  cover property ($fell(engineRun) && portIrqFlag);
endmodule

bind sdc_spi_dma_control sdc_spi_dma_control_sva #(.CNT_W(CNT_W)) i_sdc_spi_dma_control_sva (
  .clk, .rstn, .avAddress, .avRead, .avWrite, .avWriteData, .avWaitRequest, .masterMode,
  .clkRateSel, .byteDone, .xferReq, .autoSlaveSelectN, .memReq, .portIrqFlag, .engineRun);

//--- test/sdc_far_model.sv
// model of the spi shift engine and the general sram beside the dma control block
`timescale 1ns/100ps
module sdc_far_model (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // engine side
  input  wire sdc_pkg::sdc_xfer_t    xferReq,
  input  wire logic [7:0]            lat,
  output logic                       byteDone,
  output logic [7:0]                 rxByte,
  // sram side
  input  wire sdc_pkg::sdc_mem_req_t memReq,
  output logic [7:0]                 memRdata
);
  import sdc_pkg::*;
  int          startCnt, doneCnt, wrCnt;
  logic [7:0]  waitCnt, lastTx, lastWrData;
  logic [11:0] lastWrAddr;
  // idle buses show the inverse of their last value so stale data never looks valid
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {waitCnt, byteDone, rxByte, memRdata, lastTx, lastWrData, lastWrAddr} <= 53'h0;
      {startCnt, doneCnt, wrCnt} <= '0;
    end else begin
      memRdata <= memReq.rd ? (memReq.addr[7:0] ^ 8'h3c) : ~memRdata;
      byteDone <= waitCnt == 8'h01;
      rxByte <= (waitCnt == 8'h01) ? (8'(doneCnt) ^ 8'ha0) : ~rxByte;
      // a byte is clocked only after the engine primed the shifter
      if (xferReq.start) begin
        waitCnt <= lat;
        lastTx <= xferReq.data;
        startCnt <= startCnt + 1;
      end else if (waitCnt != 8'h00) begin
        waitCnt <= waitCnt - 8'h01;
      end
      if (waitCnt == 8'h01) begin
        doneCnt <= doneCnt + 1;
      end
      if (memReq.wr) begin
        {lastWrAddr, lastWrData} <= {memReq.addr, memReq.wdata};
        wrCnt <= wrCnt + 1;
      end
    end
  end
endmodule

//--- test/sdc_spi_dma_control_tb_top.sv
// testbench for the spi dma control block
`timescale 1ns/100ps
`include "sdc_cfg.svh"
module sdc_spi_dma_control_tb_top;
  import sdc_pkg::*;
  localparam logic [13:0] A_TXP  = `SDC_ADDR(`SDC_IDX_TXP);
  localparam logic [13:0] A_RXP  = `SDC_ADDR(`SDC_IDX_RXP);
  localparam logic [13:0] A_CNT  = `SDC_ADDR(`SDC_IDX_CNT);
  localparam logic [13:0] A_DWC  = `SDC_ADDR(`SDC_IDX_DWC);
  localparam logic [13:0] A_MODE = `SDC_ADDR(`SDC_IDX_MODE);
  localparam logic [13:0] A_STAT = `SDC_ADDR(`SDC_IDX_STAT);
  logic         clk, rstn, avRead, avWrite, avWaitRequest, masterMode, byteDone;
  logic         autoSlaveSelectN, portIrqFlag, engineRun;
  logic [13:0]  avAddress;
  logic [31:0]  avWriteData, avReadData, q;
  logic [1:0]   clkRateSel;
  logic [7:0]   rxByte, memRdata, lat;
  sdc_xfer_t    xferReq;
  sdc_mem_req_t memReq;
  int           errors, tests_run, d0, s0, w0;
  sdc_spi_dma_control i_sdc_spi_dma_control (.clk, .rstn, .avAddress, .avRead, .avWrite,
    .avByteEnable(4'h3), .avWriteData, .avReadData, .avWaitRequest, .masterMode,
    .clkRateSel, .byteDone, .rxByte, .xferReq, .autoSlaveSelectN, .memReq, .memRdata,
    .portIrqFlag, .engineRun);
  sdc_far_model i_sdc_far_model (.clk, .rstn, .xferReq, .lat, .byteDone, .rxByte, .memReq,
    .memRdata);
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one bus access: the request stands until waitrequest is sampled low
  task automatic acc(input logic w, input logic [13:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {avAddress, avWriteData, avWrite, avRead} <= {a, d, w, !w};
    do begin
      @(posedge clk);
      n++;
    end while (avWaitRequest !== 1'b0 && n < 20);
    q = avReadData;
    {avWrite, avRead} <= 2'b00;
    if (n >= 20) begin
      errors++;
      end_sim();
    end
  endtask
  task automatic rdc(input string nm, input logic [13:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  function automatic bit met(input int k, input int t);
    case (k)
      0: return engineRun === 1'b0;
      1: return i_sdc_far_model.startCnt >= t;
      default: return i_sdc_far_model.doneCnt >= t;
    endcase
  endfunction
  task automatic waitFor(input int k, input int t);
    int n;
    n = 0;
    while (!met(k, t) && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 5000) begin
      errors++;
      end_sim();
    end
  endtask
  // registers are set up only while idle; a running engine is written only to stop it
  task automatic xfer(input logic [31:0] tp, rp, cnt, dwc, mode);
    logic [31:0] v [4];
    v = '{tp, rp, cnt, dwc};
    for (int i = 0; i < 4; i++) acc(1'b1, A_TXP + 14'(8 * i), v[i]);
    acc(1'b1, A_STAT, 32'h1);
    {d0, s0, w0} = {i_sdc_far_model.doneCnt, i_sdc_far_model.startCnt, i_sdc_far_model.wrCnt};
    acc(1'b1, A_MODE, mode);
  endtask
  task automatic drain();
    waitFor(1, s0 + 1);
    waitFor(0, 0);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {errors, tests_run} = '0;
    {rstn, avRead, avWrite, avAddress, avWriteData, masterMode, clkRateSel} = '0;
    lat = 8'h02;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rdc("mode reset", A_MODE, 32'h0);
    rdc("dwc reset", A_DWC, 32'h0);
    rdc("unmapped", 14'h0004, 32'h0);
    acc(1'b1, A_DWC, 32'ha5);
    rdc("dwc fields", A_DWC, 32'ha5);
    acc(1'b1, A_MODE, 32'hc2);
    rdc("gap irq forced", A_MODE, 32'hc0);
    acc(1'b1, A_MODE, 32'h02);
    rdc("gap irq free", A_MODE, 32'h02);
    masterMode <= 1'b1;
    for (int r = 0; r < 3; r++) begin
      clkRateSel <= 2'(r);
      xfer(32'h100, 32'h200, 32'h3, 32'h0, 32'h39 | 32'((r + 1) << 6));
      drain();
      rdc("count end", A_CNT, 32'h0);
      rdc("tx ptr inc", A_TXP, 32'h104);
      rdc("rx ptr inc", A_RXP, 32'h204);
      chk("rx writes", w0 + 4, i_sdc_far_model.wrCnt);
      chk("rx addr", 32'h203, i_sdc_far_model.lastWrAddr);
      chk("rx data", 8'(d0 + 3) ^ 8'ha0, i_sdc_far_model.lastWrData);
      chk("tx data", 32'h3f, i_sdc_far_model.lastTx);
      chk("select idle", 1'b1, autoSlaveSelectN);
      rdc("flag done", A_STAT, 32'h1);
      acc(1'b1, A_STAT, 32'h1);
      rdc("flag clear", A_STAT, 32'h0);
    end
    xfer(32'h100, 32'h200, 32'h2, 32'h0, 32'h45);
    drain();
    rdc("tx ptr held", A_TXP, 32'h100);
    chk("tx only writes", w0, i_sdc_far_model.wrCnt);
    chk("tx repeat", 32'h3c, i_sdc_far_model.lastTx);
    chk("select idle", 1'b1, autoSlaveSelectN);
    masterMode <= 1'b0;
    xfer(32'h100, 32'h300, 32'h1, 32'h0, 32'h01);
    drain();
    rdc("rx ptr held", A_RXP, 32'h300);
    chk("rx overwrite", 32'h300, i_sdc_far_model.lastWrAddr);
    chk("rx last byte", 8'(d0 + 1) ^ 8'ha0, i_sdc_far_model.lastWrData);
    masterMode <= 1'b1;
    lat <= 8'h14;
    xfer(32'h100, 32'h200, 32'h9, 32'h0, 32'h39);
    waitFor(1, s0 + 1);
    acc(1'b1, A_MODE, 32'h38);
    waitFor(2, d0 + 1);
    rdc("abort count", A_CNT, 32'h9);
    rdc("abort tx ptr", A_TXP, 32'h100);
    rdc("abort rx ptr", A_RXP, 32'h200);
    chk("abort writes", w0, i_sdc_far_model.wrCnt);
    chk("abort starts", s0 + 1, i_sdc_far_model.startCnt);
    chk("abort run", 1'b0, engineRun);
    masterMode <= 1'b0;
    lat <= 8'h1e;
    xfer(32'h100, 32'h300, 32'h0, 32'h30, 32'h03);
    waitFor(1, s0 + 1);
    rdc("in session", A_MODE, 32'h03);
    rdc("gap field", A_DWC, 32'h30);
    rdc("tx ptr", A_TXP, 32'h100);
    rdc("gap timeout", A_STAT, 32'h3);
    drain();
    lat <= 8'h28;
    xfer(32'h100, 32'h300, 32'h5, 32'h02, 32'h11);
    waitFor(2, d0 + 2);
    rdc("above level", A_STAT, 32'h2);
    waitFor(2, d0 + 4);
    rdc("level reached", A_STAT, 32'h3);
    drain();
    rdc("rx ptr slave", A_RXP, 32'h306);
    end_sim();
  end
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    end_sim();
  end
endmodule
